// file: pkg/mie_pkg.sv
// Constants, types and decoding for the instruction subset execution unit.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
//
// Contract
// - OR literal into accumulator stores the result there and updates the zero flag.
// - Load literal puts the literal into the accumulator, no flag changes.
// - Store accumulator copies it into the addressed file register, no flag changes.
// - Copy file goes to accumulator or back to itself, zero flag always updated.
// - Return from interrupt loads program counter from stack top, sets global enable.
// - Rotate left: old carry into bit 0, old bit 7 into carry, only carry changes.
// - Rotate left result goes to accumulator for target 0, file register for 1.
// - Return pops the stack in the same cycle that the program counter is loaded.
package mie_pkg;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int INSTR_W = 14;
	localparam int PC_W = 11;
	localparam int ACC_W = 8;
	localparam int FADDR_W = 7;
	localparam int STACK_DEPTH = 8;
	localparam logic [ADR_W-1:0] OFF_INSTR = 8'h00;
	localparam logic [ADR_W-1:0] OFF_ACC = 8'h04;
	localparam logic [ADR_W-1:0] OFF_STATUS = 8'h08;
	localparam logic [ADR_W-1:0] OFF_PC = 8'h0C;
	localparam logic [ADR_W-1:0] OFF_STACK = 8'h10;
	localparam logic [ADR_W-1:0] OFF_FADDR = 8'h14;
	localparam logic [ADR_W-1:0] OFF_FDATA = 8'h18;
	localparam int ST_CARRY = 0;
	localparam int ST_ZERO = 1;
	localparam int ST_GLOBAL_IRQ_ENABLE = 2;
	localparam int ST_BUSY = 3;
	localparam logic [5:0] OPC_OR = 6'h01;
	localparam logic [5:0] OPC_LOAD = 6'h02;
	localparam logic [5:0] OPC_STORE = 6'h03;
	localparam logic [5:0] OPC_COPY = 6'h04;
	localparam logic [5:0] OPC_RET = 6'h05;
	localparam logic [5:0] OPC_ROTL = 6'h06;
	localparam int OPC_LSB = 8;
	localparam int DEST_BIT = 7;
	localparam logic [PC_W-1:0] PC_RST = 11'h000;
	localparam logic [ACC_W-1:0] ACC_RST = 8'h00;

	typedef enum logic [2:0] {MIE_NONE, MIE_OR, MIE_LOAD, MIE_STORE, MIE_COPY, MIE_RET, MIE_ROTL} mie_op_t;

	typedef struct packed {
		mie_op_t op;
		logic [ACC_W-1:0] lit;
		logic dest_file;
		logic [FADDR_W-1:0] faddr;
	} mie_instr_t;

	typedef struct packed {
		logic global_irq_enable;
		logic zero;
		logic carry;
	} mie_status_t;

	function automatic mie_instr_t mie_decode(input logic [INSTR_W-1:0] w);
		mie_instr_t r;
		r.lit = w[ACC_W-1:0];
		r.dest_file = w[DEST_BIT];
		r.faddr = w[FADDR_W-1:0];
		case (w[INSTR_W-1:OPC_LSB])
			OPC_OR: r.op = MIE_OR;
			OPC_LOAD: r.op = MIE_LOAD;
			OPC_STORE: r.op = MIE_STORE;
			OPC_COPY: r.op = MIE_COPY;
			OPC_RET: r.op = MIE_RET;
			OPC_ROTL: r.op = MIE_ROTL;
			default: r.op = MIE_NONE;
		endcase
		return r;
	endfunction
endpackage

// file: logic/mie_exec.sv
// Execution unit for a subset of 8-bit microcontroller instructions.
// Software drives it over classic Wishbone; all state sits on clk_in.
//
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
module mie_exec (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [mie_pkg::ADR_W-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [mie_pkg::DAT_W-1:0] wb_dat_in,
	output logic [mie_pkg::DAT_W-1:0] wb_dat_out,
	output logic wb_ack_out,
	output logic busy_out,
	output logic global_irq_enable_out
);
	import mie_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_EXEC2} mie_state_t;

	localparam int SP_W = $clog2(STACK_DEPTH);
	localparam int FDEPTH = 1 << FADDR_W;

	mie_state_t state_q, state_d;
	logic [INSTR_W-1:0] ir_q, ir_d;
	logic [ACC_W-1:0] acc_q, acc_d;
	mie_status_t st_q, st_d;
	logic [PC_W-1:0] pc_q, pc_d;
	logic [SP_W-1:0] sp_q, sp_d;
	logic [SP_W:0] depth_q, depth_d;
	logic [FADDR_W-1:0] faddr_q, faddr_d;
	logic ack_q, ack_d;
	logic [DAT_W-1:0] rdat_q, rdat_d;
	logic [ACC_W-1:0] file_q [FDEPTH];
	logic [PC_W-1:0] stack_q [STACK_DEPTH];
	logic f_we;
	logic [FADDR_W-1:0] f_wa;
	logic [ACC_W-1:0] f_wd;
	logic s_we;
	logic [SP_W-1:0] s_wa;
	logic [PC_W-1:0] s_wd;
	mie_instr_t dec;
	logic [ACC_W-1:0] fval;
	logic [ACC_W-1:0] rot;
	logic [ACC_W-1:0] orv;
	logic req;
	logic wr_take;
	logic [DAT_W-1:0] wdat;

	// Byte lanes not selected keep their old contents
	function automatic logic [DAT_W-1:0] lane_merge(input logic [DAT_W-1:0] old, input logic [DAT_W-1:0] nw,
			input logic [3:0] sel);
		logic [DAT_W-1:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	assign dec = mie_decode(ir_q);
	assign fval = file_q[dec.faddr];
	assign rot = {fval[ACC_W-2:0], st_q.carry};
	assign orv = acc_q | dec.lit;
	assign req = wb_cyc_in & wb_stb_in;
	// Writes land on the edge where the master sees ack
	assign wr_take = req & wb_we_in & ack_q;
	assign busy_out = (state_q != ST_IDLE);
	assign global_irq_enable_out = st_q.global_irq_enable;
	assign wb_ack_out = ack_q;
	assign wb_dat_out = rdat_q;

	// Bus slave: ack one cycle after the request, dropped the cycle after
	always_comb begin
		ack_d = req & ~ack_q;
		rdat_d = rdat_q;
		if (req & ~ack_q) begin
			rdat_d = '0;
			case (wb_adr_in)
				OFF_INSTR: rdat_d[INSTR_W-1:0] = ir_q;
				OFF_ACC: rdat_d[ACC_W-1:0] = acc_q;
				OFF_STATUS: begin
					rdat_d[ST_CARRY] = st_q.carry;
					rdat_d[ST_ZERO] = st_q.zero;
					rdat_d[ST_GLOBAL_IRQ_ENABLE] = st_q.global_irq_enable;
					rdat_d[ST_BUSY] = busy_out;
				end
				OFF_PC: rdat_d[PC_W-1:0] = pc_q;
				OFF_STACK: rdat_d[SP_W:0] = depth_q;
				OFF_FADDR: rdat_d[FADDR_W-1:0] = faddr_q;
				OFF_FDATA: rdat_d[ACC_W-1:0] = file_q[faddr_q];
				default: rdat_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ack_q <= 1'b0;
			rdat_q <= '0;
		end else begin
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	// Core execution and software writes; software writes are dropped while busy
	always_comb begin
		state_d = state_q;
		ir_d = ir_q;
		acc_d = acc_q;
		st_d = st_q;
		pc_d = pc_q;
		sp_d = sp_q;
		depth_d = depth_q;
		faddr_d = faddr_q;
		f_we = 1'b0;
		f_wa = dec.faddr;
		f_wd = '0;
		s_we = 1'b0;
		s_wa = sp_q;
		s_wd = '0;
		wdat = '0;
		case (state_q)
			ST_IDLE: begin
				if (wr_take) begin
					case (wb_adr_in)
						OFF_INSTR: begin
							wdat = lane_merge({{(DAT_W-INSTR_W){1'b0}}, ir_q}, wb_dat_in, wb_sel_in);
							ir_d = wdat[INSTR_W-1:0];
							state_d = ST_EXEC;
						end
						OFF_ACC: begin
							wdat = lane_merge({{(DAT_W-ACC_W){1'b0}}, acc_q}, wb_dat_in, wb_sel_in);
							acc_d = wdat[ACC_W-1:0];
						end
						OFF_STATUS: begin
							if (wb_sel_in[0]) begin
								st_d.carry = wb_dat_in[ST_CARRY];
								st_d.zero = wb_dat_in[ST_ZERO];
								st_d.global_irq_enable = wb_dat_in[ST_GLOBAL_IRQ_ENABLE];
							end
						end
						OFF_PC: begin
							wdat = lane_merge({{(DAT_W-PC_W){1'b0}}, pc_q}, wb_dat_in, wb_sel_in);
							pc_d = wdat[PC_W-1:0];
						end
						OFF_STACK: begin
							// Push; the oldest entry is overwritten once the stack is full
							s_we = 1'b1;
							s_wa = SP_W'(sp_q + 1'b1);
							s_wd = wb_dat_in[PC_W-1:0];
							sp_d = SP_W'(sp_q + 1'b1);
							if (depth_q != (SP_W+1)'(STACK_DEPTH))
								depth_d = (SP_W+1)'(depth_q + 1'b1);
						end
						OFF_FADDR: begin
							if (wb_sel_in[0])
								faddr_d = wb_dat_in[FADDR_W-1:0];
						end
						OFF_FDATA: begin
							if (wb_sel_in[0]) begin
								f_we = 1'b1;
								f_wa = faddr_q;
								f_wd = wb_dat_in[ACC_W-1:0];
							end
						end
						default: ;
					endcase
				end
			end
			ST_EXEC: begin
				state_d = ST_IDLE;
				pc_d = PC_W'(pc_q + 1'b1);
				case (dec.op)
					MIE_OR: begin
						acc_d = orv;
						st_d.zero = (orv == '0);
					end
					MIE_LOAD: acc_d = dec.lit;
					MIE_STORE: begin
						f_we = 1'b1;
						f_wd = acc_q;
					end
					MIE_COPY: begin
						st_d.zero = (fval == '0);
						if (dec.dest_file) begin
							f_we = 1'b1;
							f_wd = fval;
						end else begin
							acc_d = fval;
						end
					end
					MIE_RET: begin
						pc_d = stack_q[sp_q];
						st_d.global_irq_enable = 1'b1;
						sp_d = SP_W'(sp_q - 1'b1);
						if (depth_q != '0)
							depth_d = (SP_W+1)'(depth_q - 1'b1);
						state_d = ST_EXEC2;
					end
					MIE_ROTL: begin
						st_d.carry = fval[ACC_W-1];
						if (dec.dest_file) begin
							f_we = 1'b1;
							f_wd = rot;
						end else begin
							acc_d = rot;
						end
					end
					default: ;
				endcase
			end
			// Second cycle of a return: nothing is done but the step back to idle
			ST_EXEC2: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= ST_IDLE;
			ir_q <= '0;
			acc_q <= ACC_RST;
			st_q <= '0;
			pc_q <= PC_RST;
			sp_q <= '0;
			depth_q <= '0;
			faddr_q <= '0;
		end else begin
			state_q <= state_d;
			ir_q <= ir_d;
			acc_q <= acc_d;
			st_q <= st_d;
			pc_q <= pc_d;
			sp_q <= sp_d;
			depth_q <= depth_d;
			faddr_q <= faddr_d;
		end
	end

	// Arrays are data, not control, so they are left out of reset
	always_ff @(posedge clk_in) begin
		if (f_we)
			file_q[f_wa] <= f_wd;
		if (s_we)
			stack_q[s_wa] <= s_wd;
	end

	// Checks sit on the core clock; none of them runs while reset is held
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	logic exec_now;
	assign exec_now = (state_q == ST_EXEC);

	AST_OR_LIT: assert property (exec_now && dec.op == MIE_OR |=>
		acc_q == $past(orv) && st_q.zero == (acc_q == '0) && st_q.carry == $past(st_q.carry))
		else $error("OR literal result or zero flag wrong");
	AST_OR_KEEP: assert property (exec_now && dec.op == MIE_OR |=>
		st_q.global_irq_enable == $past(st_q.global_irq_enable))
		else $error("OR literal changed the global enable");
	AST_LOAD_LIT: assert property (exec_now && dec.op == MIE_LOAD |=>
		acc_q == $past(dec.lit) && st_q == $past(st_q))
		else $error("Load literal wrong or flags changed");
	AST_STORE_ACC: assert property (exec_now && dec.op == MIE_STORE |=>
		file_q[$past(dec.faddr)] == $past(acc_q) && st_q == $past(st_q) && acc_q == $past(acc_q))
		else $error("Store accumulator wrong or flags changed");
	AST_COPY_FILE: assert property (exec_now && dec.op == MIE_COPY |=>
		st_q.zero == ($past(fval) == '0) && ($past(dec.dest_file) || acc_q == $past(fval)))
		else $error("Copy file result or zero flag wrong");
	AST_RET_PC: assert property (exec_now && dec.op == MIE_RET |=>
		pc_q == $past(stack_q[sp_q]) && st_q.global_irq_enable &&
		st_q.zero == $past(st_q.zero) && st_q.carry == $past(st_q.carry))
		else $error("Return did not load PC or set global enable");
	AST_ROTL_FLAG: assert property (exec_now && dec.op == MIE_ROTL |=>
		st_q.carry == $past(fval[ACC_W-1]) && st_q.zero == $past(st_q.zero) &&
		st_q.global_irq_enable == $past(st_q.global_irq_enable))
		else $error("Rotate left carry handling wrong");
	AST_ROTL_DEST: assert property (exec_now && dec.op == MIE_ROTL && !dec.dest_file |=>
		acc_q == {$past(fval[ACC_W-2:0]), $past(st_q.carry)})
		else $error("Rotate left accumulator result wrong");
	AST_ROTL_FILE: assert property (exec_now && dec.op == MIE_ROTL && dec.dest_file |=>
		file_q[$past(dec.faddr)] == $past(rot) && acc_q == $past(acc_q))
		else $error("Rotate left file result wrong");
	AST_RET_POP: assert property (exec_now && dec.op == MIE_RET |=>
		sp_q == SP_W'($past(sp_q) - 1'b1))
		else $error("Return did not pop the stack");
	AST_CYCLES_ONE: assert property (exec_now && dec.op != MIE_RET |=>
		state_q == ST_IDLE && pc_q == PC_W'($past(pc_q) + 1'b1))
		else $error("Single cycle instruction overran or PC did not step");
	AST_CYCLES_RET: assert property (exec_now && dec.op == MIE_RET |=>
		state_q == ST_EXEC2 ##1 state_q == ST_IDLE)
		else $error("Return did not take two cycles");

	// Target 1 must leave the accumulator alone and rewrite the same byte
	AST_COPY_BACK: assert property (exec_now && dec.op == MIE_COPY && dec.dest_file |=>
		file_q[$past(dec.faddr)] == $past(fval) && acc_q == $past(acc_q))
		else $error("Copy file back to itself wrong");
	AST_COPY_KEEP: assert property (exec_now && dec.op == MIE_COPY |=>
		st_q.carry == $past(st_q.carry) && st_q.global_irq_enable == $past(st_q.global_irq_enable))
		else $error("Copy file changed a flag other than zero");

	// An empty stack wraps the pointer but never underflows the depth count
	AST_RET_DEPTH: assert property (exec_now && dec.op == MIE_RET && depth_q != '0 |=>
		depth_q == (SP_W+1)'($past(depth_q) - 1'b1))
		else $error("Return did not lower the stack depth");
endmodule

// file: bench/tb.sv
// Self-checking bench for the instruction subset execution unit.
// Drives the classic Wishbone port directly; no partner model is needed.
`timescale 1ns/10ps
module tb;
	import mie_pkg::*;
	logic clk_in, reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in;
	logic [ADR_W-1:0] wb_adr_in;
	logic [3:0] wb_sel_in;
	logic [DAT_W-1:0] wb_dat_in, wb_dat_out;
	logic wb_ack_out, busy_out, global_irq_enable_out;
	int num_errors, n_checks, busy_cnt;
	logic [3:0] bus_sel = 4'hF;

	mie_exec uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
		.wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
		.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .busy_out(busy_out),
		.global_irq_enable_out(global_irq_enable_out));

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	// Busy cycles seen at rising edges, used to time each instruction
	always @(posedge clk_in) begin
		if (busy_out === 1'b1) busy_cnt <= busy_cnt + 1;
	end

	task automatic summarize();
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One classic cycle; waits for ack under a bound, takes data at the ack edge
	task automatic bus(input logic we, input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] dat,
		output logic [DAT_W-1:0] rdat);
		int i;
		@(posedge clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_sel_in <= bus_sel;
		wb_adr_in <= adr;
		wb_dat_in <= dat;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_in);
			if (wb_ack_out === 1'b1) break;
		end
		if (i == 20) begin
			num_errors++;
			$display("CHECK FAILED at %0t: no ack", $time);
			summarize();
		end
		rdat = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in <= 1'b0;
	endtask

	task automatic wr(input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] dat);
		logic [DAT_W-1:0] d;
		bus(1'b1, adr, dat, d);
	endtask

	task automatic rdc(input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] exp);
		logic [DAT_W-1:0] d;
		bus(1'b0, adr, 32'h0, d);
		chk(d, exp);
	endtask

	// Issue one instruction, poll busy, then compare the busy cycle count
	task automatic exe(input logic [5:0] opc, input logic [7:0] k, input int ncyc);
		logic [DAT_W-1:0] d;
		int b;
		int i;
		b = busy_cnt;
		wr(OFF_INSTR, {18'h0, opc, k});
		for (i = 0; i < 20; i++) begin
			bus(1'b0, OFF_STATUS, 32'h0, d);
			if (d[ST_BUSY] === 1'b0) break;
		end
		if (i == 20) begin
			num_errors++;
			$display("CHECK FAILED at %0t: busy stuck", $time);
			summarize();
		end
		chk(DAT_W'(busy_cnt - b), DAT_W'(ncyc));
	endtask

	initial begin
		reset_n_in = 1'b0;
		wb_cyc_in = 1'b0;
		wb_stb_in = 1'b0;
		wb_we_in = 1'b0;
		wb_adr_in = 8'h00;
		wb_sel_in = 4'hF;
		wb_dat_in = 32'h0;
		repeat (20) @(posedge clk_in);
		reset_n_in <= 1'b1;
		rdc(OFF_ACC, 32'h0);
		rdc(OFF_STATUS, 32'h0);
		rdc(OFF_PC, 32'h0);
		rdc(OFF_STACK, 32'h0);
		chk(DAT_W'(global_irq_enable_out), 32'h0);
		// Flags preset so an unwanted change shows
		wr(OFF_STATUS, 32'h3);
		exe(OPC_LOAD, 8'hA5, 1);
		rdc(OFF_ACC, 32'hA5);
		rdc(OFF_STATUS, 32'h3);
		rdc(OFF_PC, 32'h1);
		wr(OFF_STATUS, 32'h0);
		exe(OPC_LOAD, 8'h00, 1);
		exe(OPC_OR, 8'h00, 1);
		rdc(OFF_ACC, 32'h0);
		rdc(OFF_STATUS, 32'h2);
		exe(OPC_LOAD, 8'h81, 1);
		exe(OPC_OR, 8'h5A, 1);
		rdc(OFF_ACC, 32'hDB);
		rdc(OFF_STATUS, 32'h0);
		// Top file address, carry set to catch flag damage
		wr(OFF_STATUS, 32'h1);
		exe(OPC_STORE, 8'h7F, 1);
		wr(OFF_FADDR, 32'h7F);
		rdc(OFF_FDATA, 32'hDB);
		rdc(OFF_STATUS, 32'h1);
		wr(OFF_FADDR, 32'h10);
		wr(OFF_FDATA, 32'h0);
		exe(OPC_COPY, 8'h10, 1);
		rdc(OFF_ACC, 32'h0);
		rdc(OFF_STATUS, 32'h3);
		exe(OPC_COPY, 8'hFF, 1);
		rdc(OFF_ACC, 32'h0);
		rdc(OFF_STATUS, 32'h1);
		wr(OFF_FADDR, 32'h7F);
		rdc(OFF_FDATA, 32'hDB);
		// Rotate into file then accumulator, out of bit 7 and in through carry, zero must hold
		wr(OFF_FADDR, 32'h20);
		wr(OFF_FDATA, 32'h81);
		wr(OFF_STATUS, 32'h2);
		exe(OPC_ROTL, 8'hA0, 1);
		rdc(OFF_FDATA, 32'h02);
		rdc(OFF_STATUS, 32'h3);
		rdc(OFF_ACC, 32'h0);
		exe(OPC_ROTL, 8'h20, 1);
		rdc(OFF_ACC, 32'h05);
		rdc(OFF_STATUS, 32'h2);
		rdc(OFF_FDATA, 32'h02);
		// Two returns unwind two pushed entries
		wr(OFF_STACK, 32'h123);
		wr(OFF_STACK, 32'h456);
		rdc(OFF_STACK, 32'h2);
		wr(OFF_STATUS, 32'h1);
		exe(OPC_RET, 8'h00, 2);
		rdc(OFF_PC, 32'h456);
		rdc(OFF_STATUS, 32'h5);
		chk(DAT_W'(global_irq_enable_out), 32'h1);
		rdc(OFF_STACK, 32'h1);
		exe(OPC_RET, 8'h00, 2);
		rdc(OFF_PC, 32'h123);
		rdc(OFF_STACK, 32'h0);
		// Unmapped place reads zero and ignores writes
		wr(8'h40, 32'hFFFFFFFF);
		rdc(8'h40, 32'h0);
		// Unknown opcode only steps the PC
		exe(6'h3F, 8'hFF, 1);
		rdc(OFF_PC, 32'h124);
		rdc(OFF_ACC, 32'h05);
		// An accumulator write with no byte lane selected changes nothing
		bus_sel = 4'h0;
		wr(OFF_ACC, 32'hFF);
		bus_sel = 4'hF;
		rdc(OFF_ACC, 32'h05);
		summarize();
	end
endmodule
